// file: hdl/lbb_bridge.sv
// Local microprocessor bus bridge: register slave and window master
// Function
// - Separate-strobe 8-bit port: single byte to address 00-11, low lane, high enable 1.
// - Separate-strobe 16-bit port: odd bytes high lane, words at 00/10.
// - Unmapped byte-enable combinations raise an access error, no local transfer.
// - Data-strobe 8-bit port: single byte on data 15:8, size select 1.
// - Data-strobe 16-bit port: even bytes high lane, words size 0.
// - Option disables byte swapping on 16-bit transfers.
// - On data strobe, device moves data and pulls acknowledge low when done.
// - Back-to-back slave cycles accepted with slave select held low.
// - After strobe release acknowledge goes high, tri-stated on select release.
// - Window access requests the local bus; transfer waits for grant.
// - Master drives address, size, page select, direction, then data strobe.
// - Master transfer ends on acknowledge or wait-timer expiry.
// - Three 8 kByte pages map to page selects; fourth page invalid.
// - Master transfers only while the master enable bit is set.
// - Local bus clock is a feed-through of the system clock.
`timescale 1ns/100ps
`default_nettype none
module lbb_bridge (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        style_ds_i,
    input  wire logic        port16_i,
    input  wire logic        swap_disable_i,
    input  wire logic        master_enable_bit_i,
    input  wire logic        req_valid_i,
    input  wire logic [14:0] req_addr_i,
    input  wire logic [3:0]  req_be_n_i,
    input  wire logic        req_write_i,
    input  wire logic [31:0] req_wdata_i,
    output logic             req_busy_o,
    output logic             req_done_o,
    output logic             req_error_o,
    output logic             req_timeout_o,
    output logic [31:0]      req_rdata_o,
    output logic             reg_req_o,
    output logic             reg_write_o,
    output logic [11:0]      reg_addr_o,
    output logic [15:0]      reg_wdata_o,
    input  wire logic        reg_ack_i,
    input  wire logic [15:0] reg_rdata_i,
    output wire logic        local_bus_clock_o,
    input  wire logic [12:0] local_address_i,
    output logic [12:0]      local_address_o,
    output logic             local_address_oe_o,
    input  wire logic [15:0] local_data_i,
    output logic [15:0]      local_data_o,
    output logic             local_data_oe_o,
    output logic             high_byte_enable_n_o,
    output logic             byte_size_select_o,
    input  wire logic        slave_select_n_i,
    output logic             page_select_a_n_o,
    output logic             page_select_b_n_o,
    input  wire logic        write_not_read_i,
    output logic             write_not_read_o,
    output logic             write_not_read_oe_o,
    input  wire logic        data_strobe_n_i,
    output logic             data_strobe_n_o,
    output logic             data_strobe_oe_o,
    input  wire logic        transfer_acknowledge_n_i,
    output logic             transfer_acknowledge_n_o,
    output logic             transfer_acknowledge_oe_o,
    output logic             bus_request_n_o,
    input  wire logic        bus_grant_n_i,
    output logic             grant_acknowledge_n_o
);
    localparam int AST_WAIT = lbb_pkg::WAIT_CYC;

    lbb_pkg::lbb_sst_t  sst;
    lbb_pkg::lbb_sst_t  next_sst;
    lbb_pkg::lbb_mst_t  mst;
    lbb_pkg::lbb_mst_t  next_mst;
    lbb_pkg::lbb_pins_t pins;
    lbb_pkg::lbb_pins_t next_pins;
    lbb_pkg::lbb_map_t  map_q;
    lbb_pkg::lbb_map_t  next_map_q;
    lbb_pkg::lbb_map_t  map_now;
    logic [1:0]         page_now;
    logic               take;
    logic               slave_start;
    logic [7:0]         timer;
    logic [7:0]         next_timer;
    logic               wr_q;
    logic               next_wr_q;
    logic               next_busy;
    logic               next_done;
    logic               next_error;
    logic               next_timeout;
    logic [31:0]        next_rdata;
    logic               next_reg_req;
    logic               next_reg_write;
    logic [11:0]        next_reg_addr;
    logic [15:0]        next_reg_wdata;

    // Byte-enable to local lane mapping for the selected style and width
    function automatic lbb_pkg::lbb_map_t map_be(input logic ds, input logic p16,
                                                  input logic nosw, input logic [3:0] be);
        lbb_pkg::lbb_map_t m;
        logic [1:0]        base;
        m = '0;
        m.bsel = 1'b1;
        base = (be == lbb_pkg::BE_LO_WORD) ? lbb_pkg::ADDR_LO_WORD : lbb_pkg::ADDR_HI_WORD;
        for (int k = 0; k < 4; k++) begin
            if (be == ~(4'h1 << k)) begin
                m.ok = 1'b1;
                m.lane_addr = k[1:0];
                if (ds == lbb_pkg::STYLE_DS) begin
                    m.hi_en  = !p16 || !k[0];
                    m.lo_en  = p16 && k[0];
                end else begin
                    m.hi_en  = p16 && k[0];
                    m.lo_en  = !p16 || !k[0];
                    m.bsel   = !(p16 && k[0]);
                end
                m.hi_src = k[1:0];
                m.lo_src = k[1:0];
            end
        end
        if (p16 && (be == lbb_pkg::BE_LO_WORD || be == lbb_pkg::BE_HI_WORD)) begin
            m.ok    = 1'b1;
            m.lane_addr = base;
            m.bsel  = 1'b0;
            m.hi_en = 1'b1;
            m.lo_en = 1'b1;
            // Data-strobe style swaps lanes on words unless the option turns it off
            if (ds == lbb_pkg::STYLE_DS && !nosw) begin
                m.hi_src = base;
                m.lo_src = base + 2'h1;
            end else begin
                m.hi_src = base + 2'h1;
                m.lo_src = base;
            end
        end
        return m;
    endfunction

    assign local_bus_clock_o = mclk_i;
    assign map_now  = map_be(style_ds_i, port16_i, swap_disable_i, req_be_n_i);
    assign page_now = req_addr_i[lbb_pkg::PAGE_MSB:lbb_pkg::PAGE_LSB];
    assign take     = req_valid_i && mst == lbb_pkg::M_IDLE && sst == lbb_pkg::S_IDLE;
    // Master wins a same-cycle tie; the processor simply sees a later acknowledge
    assign slave_start = !slave_select_n_i && !data_strobe_n_i && mst == lbb_pkg::M_IDLE
                         && !take;

    always_comb begin
        next_sst       = sst;
        next_mst       = mst;
        next_pins      = pins;
        next_map_q     = map_q;
        next_timer     = timer;
        next_wr_q      = wr_q;
        next_done      = 1'b0;
        next_error     = 1'b0;
        next_timeout   = 1'b0;
        next_rdata     = req_rdata_o;
        next_reg_req   = 1'b0;
        next_reg_write = reg_write_o;
        next_reg_addr  = reg_addr_o;
        next_reg_wdata = reg_wdata_o;
        unique case (sst)
            lbb_pkg::S_IDLE, lbb_pkg::S_HOLD: begin
                if (slave_start) begin
                    next_reg_req     = 1'b1;
                    next_reg_write   = write_not_read_i;
                    next_reg_addr    = local_address_i[12:1];
                    next_reg_wdata   = local_data_i;
                    next_pins.ack_oe = 1'b1;
                    next_pins.ack_n  = 1'b1;
                    next_sst         = lbb_pkg::S_WAIT;
                end else if (sst == lbb_pkg::S_HOLD && slave_select_n_i) begin
                    next_pins.ack_oe = 1'b0;
                    next_sst         = lbb_pkg::S_IDLE;
                end
            end
            lbb_pkg::S_WAIT: begin
                if (reg_ack_i) begin
                    next_pins.data_oe = !reg_write_o;
                    next_pins.data    = reg_rdata_i;
                    next_pins.ack_n   = 1'b0;
                    next_sst          = lbb_pkg::S_ACK;
                end
            end
            lbb_pkg::S_ACK: begin
                if (data_strobe_n_i) begin
                    next_pins.data_oe = 1'b0;
                    next_pins.ack_n   = 1'b1;
                    next_sst          = lbb_pkg::S_HOLD;
                end
            end
        endcase
        unique case (mst)
            lbb_pkg::M_IDLE: begin
                if (take) begin
                    if (!master_enable_bit_i) begin
                        next_done = 1'b1;
                    end else if (!map_now.ok || page_now == lbb_pkg::PAGE_INVALID) begin
                        next_done  = 1'b1;
                        next_error = 1'b1;
                    end else begin
                        next_map_q     = map_now;
                        next_wr_q      = req_write_i;
                        next_pins.addr = {req_addr_i[12:2], map_now.lane_addr};
                        // Page 2 asserts both selects, so each select is high only on the other page
                        next_pins.pga_n = page_now == lbb_pkg::PAGE_1;
                        next_pins.pgb_n = page_now == lbb_pkg::PAGE_0;
                        next_pins.data = {req_wdata_i[8*map_now.hi_src +: 8],
                                          req_wdata_i[8*map_now.lo_src +: 8]};
                        next_pins.br_n = 1'b0;
                        next_mst       = lbb_pkg::M_REQ;
                    end
                end
            end
            lbb_pkg::M_REQ: begin
                if (!bus_grant_n_i) begin
                    next_pins.gack_n  = 1'b0;
                    next_pins.addr_oe = 1'b1;
                    next_pins.wnr     = wr_q;
                    next_pins.wnr_oe  = 1'b1;
                    next_pins.data_oe = wr_q;
                    next_pins.ds_oe   = 1'b1;
                    next_pins.ds_n    = 1'b1;
                    next_pins.hbe_n = style_ds_i ? 1'b1 : map_q.bsel;
                    next_pins.size  = style_ds_i ? map_q.bsel : 1'b1;
                    next_mst        = lbb_pkg::M_ADDR;
                end
            end
            lbb_pkg::M_ADDR: begin
                next_pins.ds_n = 1'b0;
                next_timer     = 8'(lbb_pkg::WAIT_CYC - 1);
                next_mst       = lbb_pkg::M_STRB;
            end
            lbb_pkg::M_STRB: begin
                next_timer = timer - 8'h01;
                if (!transfer_acknowledge_n_i || timer == 8'h00) begin
                    next_timeout   = transfer_acknowledge_n_i;
                    next_pins.ds_n = 1'b1;
                    if (!wr_q) begin
                        next_rdata = 32'h0000_0000;
                        if (map_q.hi_en) next_rdata[8*map_q.hi_src +: 8] = local_data_i[15:8];
                        if (map_q.lo_en) next_rdata[8*map_q.lo_src +: 8] = local_data_i[7:0];
                    end
                    next_mst = lbb_pkg::M_END;
                end
            end
            lbb_pkg::M_END: begin
                next_pins      = lbb_pkg::PINS_RST;
                next_pins.ack_n  = pins.ack_n;
                next_pins.ack_oe = pins.ack_oe;
                next_done      = 1'b1;
                next_timeout   = req_timeout_o;
                next_mst       = lbb_pkg::M_IDLE;
            end
        endcase
        next_busy = next_mst != lbb_pkg::M_IDLE || next_sst != lbb_pkg::S_IDLE;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sst           <= lbb_pkg::S_IDLE;
            mst           <= lbb_pkg::M_IDLE;
            pins          <= lbb_pkg::PINS_RST;
            map_q         <= '0;
            timer         <= 8'h00;
            wr_q          <= 1'b0;
            req_busy_o    <= 1'b0;
            req_done_o    <= 1'b0;
            req_error_o   <= 1'b0;
            req_timeout_o <= 1'b0;
            req_rdata_o   <= 32'h0000_0000;
            reg_req_o     <= 1'b0;
            reg_write_o   <= 1'b0;
            reg_addr_o    <= 12'h000;
            reg_wdata_o   <= 16'h0000;
        end else begin
            sst           <= next_sst;
            mst           <= next_mst;
            pins          <= next_pins;
            map_q         <= next_map_q;
            timer         <= next_timer;
            wr_q          <= next_wr_q;
            req_busy_o    <= next_busy;
            req_done_o    <= next_done;
            req_error_o   <= next_error;
            req_timeout_o <= next_timeout;
            req_rdata_o   <= next_rdata;
            reg_req_o     <= next_reg_req;
            reg_write_o   <= next_reg_write;
            reg_addr_o    <= next_reg_addr;
            reg_wdata_o   <= next_reg_wdata;
        end
    end

    assign local_address_o           = pins.addr;
    assign local_address_oe_o        = pins.addr_oe;
    assign local_data_o              = pins.data;
    assign local_data_oe_o           = pins.data_oe;
    assign high_byte_enable_n_o      = pins.hbe_n;
    assign byte_size_select_o        = pins.size;
    assign page_select_a_n_o         = pins.pga_n;
    assign page_select_b_n_o         = pins.pgb_n;
    assign write_not_read_o          = pins.wnr;
    assign write_not_read_oe_o       = pins.wnr_oe;
    assign data_strobe_n_o           = pins.ds_n;
    assign data_strobe_oe_o          = pins.ds_oe;
    assign transfer_acknowledge_n_o  = pins.ack_n;
    assign transfer_acknowledge_oe_o = pins.ack_oe;
    assign bus_request_n_o           = pins.br_n;
    assign grant_acknowledge_n_o     = pins.gack_n;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence seq_strobe_on;
        $fell(data_strobe_n_o) && data_strobe_oe_o;
    endsequence
    sequence seq_strobe_off;
        $rose(data_strobe_n_o) && data_strobe_oe_o;
    endsequence

    AST_PAGE3_ERR: assert property (
        take && master_enable_bit_i && page_now == lbb_pkg::PAGE_INVALID
        |=> req_done_o && req_error_o && bus_request_n_o)
        else $error("invalid page did not raise an access error");
    AST_BAD_BE: assert property (
        take && master_enable_bit_i && !map_now.ok |=> req_error_o ##1 bus_request_n_o)
        else $error("unmapped byte enables started a transfer");
    AST_DISABLED: assert property (
        take && !master_enable_bit_i |=> req_done_o && !req_error_o && bus_request_n_o)
        else $error("master transfer started while disabled");
    AST_GRANT_FIRST: assert property (
        $fell(grant_acknowledge_n_o) |-> !$past(bus_grant_n_i) && !bus_request_n_o)
        else $error("bus taken without grant");
    AST_ADDR_BEFORE_STROBE: assert property (
        seq_strobe_on |-> local_address_oe_o && write_not_read_oe_o
        && $past(local_address_oe_o) && (!page_select_a_n_o || !page_select_b_n_o))
        else $error("strobe asserted before address phase");
    AST_WAIT_TIMEOUT: assert property (
        seq_strobe_on |-> ##[1:AST_WAIT] seq_strobe_off)
        else $error("master transfer not ended by wait timer");
    AST_ACK_ENDS: assert property (
        mst == lbb_pkg::M_STRB && !transfer_acknowledge_n_i |=> seq_strobe_off
        ##1 req_done_o && !req_timeout_o)
        else $error("acknowledge did not end master transfer");
    AST_SLAVE_ACK: assert property (
        sst == lbb_pkg::S_WAIT && reg_ack_i |=> !transfer_acknowledge_n_o
        && transfer_acknowledge_oe_o && (local_data_oe_o == !reg_write_o))
        else $error("slave acknowledge missing after register access");
    AST_ACK_HIGH: assert property (
        sst == lbb_pkg::S_ACK && data_strobe_n_i |=> transfer_acknowledge_n_o
        && transfer_acknowledge_oe_o && !local_data_oe_o)
        else $error("acknowledge not driven high after strobe release");
    AST_ACK_TRISTATE: assert property (
        sst == lbb_pkg::S_HOLD && slave_select_n_i |=> !transfer_acknowledge_oe_o)
        else $error("acknowledge still driven after select release");
    AST_BACK_TO_BACK: assert property (
        sst == lbb_pkg::S_HOLD && !slave_select_n_i && !data_strobe_n_i && !take
        |=> reg_req_o)
        else $error("back-to-back slave cycle not accepted");
endmodule
`default_nettype wire

// file: pkg/lbb_pkg.sv
// Constants, types and pin bundle of the local bus bridge
`default_nettype none
package lbb_pkg;
    localparam int CLK_PERIOD_NS = 25;
    // Wait-state timeout, counted from data strobe assertion
    localparam int WAIT_NS  = 500;
    localparam int WAIT_CYC = (WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int PAGE_MSB = 14;
    localparam int PAGE_LSB = 13;
    localparam logic [1:0] PAGE_0       = 2'h0;
    localparam logic [1:0] PAGE_1       = 2'h1;
    localparam logic [1:0] PAGE_INVALID = 2'h3;

    localparam logic STYLE_SEP = 1'b0;
    localparam logic STYLE_DS  = 1'b1;

    localparam logic [3:0] BE_LO_WORD = 4'hc;
    localparam logic [3:0] BE_HI_WORD = 4'h3;
    localparam logic [1:0] ADDR_LO_WORD = 2'h0;
    localparam logic [1:0] ADDR_HI_WORD = 2'h2;

    typedef struct packed {
        logic       ok;
        logic [1:0] lane_addr;
        logic       bsel;
        logic       hi_en;
        logic [1:0] hi_src;
        logic       lo_en;
        logic [1:0] lo_src;
    } lbb_map_t;

    typedef struct packed {
        logic [12:0] addr;
        logic        addr_oe;
        logic [15:0] data;
        logic        data_oe;
        logic        hbe_n;
        logic        size;
        logic        pga_n;
        logic        pgb_n;
        logic        wnr;
        logic        wnr_oe;
        logic        ds_n;
        logic        ds_oe;
        logic        ack_n;
        logic        ack_oe;
        logic        br_n;
        logic        gack_n;
    } lbb_pins_t;

    localparam lbb_pins_t PINS_RST = '{addr: 13'h0000, addr_oe: 1'b0, data: 16'h0000,
        data_oe: 1'b0, hbe_n: 1'b1, size: 1'b1, pga_n: 1'b1, pgb_n: 1'b1, wnr: 1'b0,
        wnr_oe: 1'b0, ds_n: 1'b1, ds_oe: 1'b0, ack_n: 1'b1, ack_oe: 1'b0, br_n: 1'b1,
        gack_n: 1'b1};

    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_ACK, S_HOLD} lbb_sst_t;
    typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_STRB, M_END} lbb_mst_t;
endpackage
`default_nettype wire

// file: testbench/lbb_far_model.sv
// Local bus arbiter and peripheral facing the bridge in master mode
`timescale 1ns/100ps
`default_nettype none
module lbb_far_model #(
    parameter int GRANT_WAIT = 2
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        bus_request_n_i,
    input  wire logic        data_strobe_n_i,
    input  wire logic        data_strobe_oe_i,
    input  wire logic        write_not_read_i,
    input  wire logic [32:0] pins_i,
    input  wire logic [7:0]  ack_delay_i,
    input  wire logic [15:0] read_word_i,
    output logic             bus_grant_n_o,
    output logic             transfer_acknowledge_n_o,
    output logic [15:0]      local_data_o,
    output logic [32:0]      cap_o,
    output logic [7:0]       strobes_o
);
    logic        ds;
    logic        ds_q;
    logic [7:0]  gcnt;
    logic [7:0]  acnt;
    logic [15:0] last;
    assign ds = data_strobe_oe_i & ~data_strobe_n_i;
    // A released bus shows the inverse of the last word, never a stale copy
    assign local_data_o = (ds & ~write_not_read_i) ? read_word_i : ~last;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gcnt <= 8'h00;
            acnt <= 8'h00;
            ds_q <= 1'b0;
            last <= 16'h0000;
            cap_o <= '0;
            strobes_o <= 8'h00;
            bus_grant_n_o <= 1'b1;
            transfer_acknowledge_n_o <= 1'b1;
        end else begin
            ds_q <= ds;
            if (bus_request_n_i) begin
                gcnt <= 8'h00;
                bus_grant_n_o <= 1'b1;
            end else if (gcnt == GRANT_WAIT[7:0]) begin
                bus_grant_n_o <= 1'b0;
            end else begin
                gcnt <= gcnt + 8'h01;
            end
            // Delay 8'hff never acknowledges, so the wait timer must end it
            if (!ds) begin
                acnt <= 8'h00;
                transfer_acknowledge_n_o <= 1'b1;
            end else begin
                acnt <= acnt + 8'h01;
                cap_o <= pins_i;
                if (acnt == ack_delay_i) begin
                    transfer_acknowledge_n_o <= 1'b0;
                end
            end
            if (ds && !ds_q) begin
                strobes_o <= strobes_o + 8'h01;
            end
            if (ds && !write_not_read_i) begin
                last <= read_word_i;
            end
        end
    end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the local bus bridge
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic mclk_i = 0, rst_n_i = 0, style_ds_i = 0, port16_i = 0, swap_disable_i = 0;
    logic master_enable_bit_i = 1, req_valid_i = 0, req_write_i = 1, reg_ack_i = 0;
    logic [14:0] req_addr_i = '0;
    logic [3:0]  req_be_n_i = 4'hf;
    logic [31:0] req_wdata_i = 32'h44332211, req_rdata_o;
    logic req_busy_o, req_done_o, req_error_o, req_timeout_o, reg_req_o, reg_write_o;
    logic [11:0] reg_addr_o;
    logic [15:0] reg_wdata_o, reg_rdata_i = '0, local_data_i, local_data_o, far_data;
    logic [15:0] sl_data = '0;
    logic [12:0] local_address_i, local_address_o, sl_addr = '0;
    logic local_bus_clock_o, local_address_oe_o, local_data_oe_o, high_byte_enable_n_o;
    logic byte_size_select_o, page_select_a_n_o, page_select_b_n_o, write_not_read_i;
    logic write_not_read_o, write_not_read_oe_o, data_strobe_n_i, data_strobe_n_o;
    logic data_strobe_oe_o, transfer_acknowledge_n_i, transfer_acknowledge_n_o, far_ack_n;
    logic transfer_acknowledge_oe_o, bus_request_n_o, bus_grant_n_i, grant_acknowledge_n_o;
    logic slave_select_n_i = 1, sl_ds_n = 1, sl_wnr = 0, d_err, d_to;
    logic [7:0]  ack_delay = 8'h02, strobes_o, rcnt = '0;
    logic [32:0] cap_o;
    logic [27:0] wr_log = '0;
    logic [43:0] r;
    int fail_count = 0, samples_checked = 0, s0;
    // Style/width/swap/error, byte enables, addr/hbe/size, data, data mask
    logic [43:0] rows [27] = '{44'h0e3001100ff, 44'h0d7002200ff, 44'h0bb003300ff,
        44'h07f004400ff, 44'h1c300000000, 44'h4e3001100ff, 44'h4d52200ff00,
        44'h4bb003300ff, 44'h47d4400ff00, 44'h4c12211ffff, 44'h4394433ffff,
        44'h59300000000, 44'h8e31100ff00, 44'h8d72200ff00, 44'h8bb3300ff00,
        44'h87f4400ff00, 44'h90300000000, 44'hce31100ff00, 44'hcd7002200ff,
        44'hcbb3300ff00, 44'hc7f004400ff, 44'hcc21122ffff, 44'hc3a3344ffff,
        44'hec22211ffff, 44'he3a4433ffff, 44'hee31100ff00, 44'hd5300000000};
    // Each shared wire sees whichever party currently drives it
    assign local_data_i = local_data_oe_o ? local_data_o : (!slave_select_n_i ? sl_data : far_data);
    assign local_address_i = local_address_oe_o ? local_address_o : sl_addr;
    assign write_not_read_i = write_not_read_oe_o ? write_not_read_o : sl_wnr;
    assign data_strobe_n_i = data_strobe_oe_o ? data_strobe_n_o : sl_ds_n;
    assign transfer_acknowledge_n_i = transfer_acknowledge_oe_o ? transfer_acknowledge_n_o : far_ack_n;
    always #12.5 mclk_i = ~mclk_i;
    lbb_bridge u_dut (.mclk_i, .rst_n_i, .style_ds_i, .port16_i, .swap_disable_i,
        .master_enable_bit_i, .req_valid_i, .req_addr_i, .req_be_n_i, .req_write_i,
        .req_wdata_i, .req_busy_o, .req_done_o, .req_error_o, .req_timeout_o, .req_rdata_o,
        .reg_req_o, .reg_write_o, .reg_addr_o, .reg_wdata_o, .reg_ack_i, .reg_rdata_i,
        .local_bus_clock_o, .local_address_i, .local_address_o, .local_address_oe_o,
        .local_data_i, .local_data_o, .local_data_oe_o, .high_byte_enable_n_o,
        .byte_size_select_o, .slave_select_n_i, .page_select_a_n_o, .page_select_b_n_o,
        .write_not_read_i, .write_not_read_o, .write_not_read_oe_o, .data_strobe_n_i,
        .data_strobe_n_o, .data_strobe_oe_o, .transfer_acknowledge_n_i,
        .transfer_acknowledge_n_o, .transfer_acknowledge_oe_o, .bus_request_n_o,
        .bus_grant_n_i, .grant_acknowledge_n_o);
    lbb_far_model u_far (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_request_n_i(bus_request_n_o),
        .data_strobe_n_i(data_strobe_n_o), .data_strobe_oe_i(data_strobe_oe_o),
        .write_not_read_i(write_not_read_o), .ack_delay_i(ack_delay), .read_word_i(16'hbeef),
        .pins_i({page_select_a_n_o, page_select_b_n_o, high_byte_enable_n_o,
        byte_size_select_o, local_address_o, local_data_o}), .bus_grant_n_o(bus_grant_n_i),
        .transfer_acknowledge_n_o(far_ack_n), .local_data_o(far_data), .cap_o(cap_o),
        .strobes_o(strobes_o));
    // Register file stand-in: answers three cycles after each request
    always @(posedge mclk_i) begin
        rcnt <= reg_req_o ? 8'h02 : (rcnt != 8'h00 ? rcnt - 8'h01 : rcnt);
        reg_ack_i <= (rcnt == 8'h01);
        reg_rdata_i <= {4'h0, reg_addr_o} ^ 16'ha500;
        if (reg_req_o && reg_write_o) wr_log <= {reg_addr_o, reg_wdata_o};
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic final_report();
        if (fail_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic req(input logic [14:0] a, input logic w, input logic [3:0] be);
        int n;
        @(posedge mclk_i);
        req_addr_i <= a;
        req_write_i <= w;
        req_be_n_i <= be;
        req_valid_i <= 1'b1;
        s0 = strobes_o;
        @(posedge mclk_i);
        req_valid_i <= 1'b0;
        n = 0;
        // Error answers pulse done right after the take edge, so look before waiting
        #1;
        while (req_done_o !== 1'b1 && n < 200) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        if (n >= 200) fail_count++;
        chk(req_busy_o, 1'b0);
        d_err = req_error_o;
        d_to = req_timeout_o;
    endtask
    task automatic sl(input logic [11:0] a, input logic w, input logic [15:0] d);
        int n;
        @(posedge mclk_i);
        sl_addr <= {a, 1'b0};
        sl_wnr <= w;
        sl_data <= d;
        slave_select_n_i <= 1'b0;
        @(posedge mclk_i);
        sl_ds_n <= 1'b0;
        n = 0;
        do begin @(posedge mclk_i); #1; n++; end
        while (transfer_acknowledge_n_o !== 1'b0 && n < 50);
        if (!w) chk(local_data_o, {4'h0, a} ^ 16'ha500);
        chk(local_data_oe_o, !w);
        @(posedge mclk_i);
        sl_ds_n <= 1'b1;
        n = 0;
        do begin @(posedge mclk_i); #1; n++; end
        while (transfer_acknowledge_n_o !== 1'b1 && n < 50);
        chk({local_data_oe_o, transfer_acknowledge_oe_o}, 2'b01);
        if (w) chk(wr_log, {a, d});
    endtask
    initial begin
        #500000;
        fail_count++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge mclk_i);
        #1 chk({bus_request_n_o, local_data_oe_o, data_strobe_oe_o, req_busy_o}, 4'h8);
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        #1 chk(local_bus_clock_o, 1'b1);
        #13 chk(local_bus_clock_o, 1'b0);
        for (int i = 0; i < 27; i++) begin
            r = rows[i];
            @(posedge mclk_i);
            {style_ds_i, port16_i, swap_disable_i} <= r[43:41];
            req(15'h0124, 1'b1, r[39:36]);
            chk({d_err, d_to, strobes_o}, {r[40], 1'b0, 8'(s0 + !r[40])});
            if (!r[40]) chk(cap_o[32:16], {2'b01, r[33:32], 11'h049, r[35:34]});
            if (!r[40]) chk(cap_o[15:0] & r[15:0], r[31:16]);
        end
        for (int p = 1; p < 4; p++) begin
            req({p[1:0], 13'h0004}, 1'b1, 4'he);
            chk({d_err, strobes_o}, {p == 3, 8'(s0 + (p != 3))});
            if (p != 3) chk(cap_o[32:31], p == 1 ? 2'b10 : 2'b00);
        end
        @(posedge mclk_i);
        {style_ds_i, port16_i, swap_disable_i} <= 3'b110;
        ack_delay <= 8'h05;
        req(15'h0010, 1'b0, 4'hc);
        chk(req_rdata_o, 32'h0000efbe);
        @(posedge mclk_i);
        ack_delay <= 8'hff;
        req(15'h0010, 1'b0, 4'hc);
        chk({d_err, d_to}, 2'b01);
        @(posedge mclk_i);
        master_enable_bit_i <= 1'b0;
        req(15'h0010, 1'b1, 4'hc);
        chk({d_err, strobes_o}, {1'b0, 8'(s0)});
        sl(12'h123, 1'b0, 16'h0000);
        sl(12'h0a5, 1'b1, 16'h5a3c);
        sl(12'h0a6, 1'b0, 16'h0000);
        @(posedge mclk_i);
        slave_select_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        #1 chk(transfer_acknowledge_oe_o, 1'b0);
        final_report();
    end
endmodule
`default_nettype wire
